// ### hdl/mid_pkg.sv
package mid_pkg;

	// Special-function space holding the two data pointer bytes.
	localparam logic [7:0] SFR_SPACE_BASE    = 8'h80;
	localparam logic [7:0] SFR_DP_LOW_ADDR   = 8'h82;
	localparam logic [7:0] SFR_DP_HIGH_ADDR  = 8'h83;
	localparam logic [7:0] DP_BYTE_RESET     = 8'h00;

	// Opcodes that need an exact match.
	localparam logic [7:0] OPC_NOP           = 8'h00;
	localparam logic [7:0] OPC_UNDEFINED     = 8'hA5;
	localparam logic [7:0] OPC_CODE_MOVE_PC  = 8'h83;
	localparam logic [7:0] OPC_XDATA_DP_RD   = 8'hE0;
	localparam logic [7:0] OPC_XDATA_DP_WR   = 8'hF0;

	// Register slot and bank field positions.
	localparam int         SLOT_MSB          = 2;
	localparam int         BANK_LSB          = 3;

	// Cycle figures; a taken conditional branch adds one more.
	localparam logic [2:0] CYC_1             = 3'h1;
	localparam logic [2:0] CYC_2             = 3'h2;
	localparam logic [2:0] CYC_3             = 3'h3;
	localparam logic [2:0] CYC_4             = 3'h4;
	localparam logic [2:0] CYC_TAKEN_EXTRA   = 3'h1;

	typedef enum logic [4:0] {
		CL_OTHER       = 5'b00000,
		CL_NOP         = 5'b00001,
		CL_PAGED_JMP   = 5'b00010,
		CL_PAGED_CALL  = 5'b00011,
		CL_LONG_JMP    = 5'b00100,
		CL_LONG_CALL   = 5'b00101,
		CL_SHORT_JMP   = 5'b00110,
		CL_JMP_IND     = 5'b00111,
		CL_JC          = 5'b01000,
		CL_JNC         = 5'b01001,
		CL_JZ          = 5'b01010,
		CL_JNZ         = 5'b01011,
		CL_JB          = 5'b01100,
		CL_JNB         = 5'b01101,
		CL_JB_CLR      = 5'b01110,
		CL_CMPJ_DIR    = 5'b01111,
		CL_CMPJ_IMM    = 5'b10000,
		CL_CMPJ_REG    = 5'b10001,
		CL_CMPJ_IND    = 5'b10010,
		CL_DECJ_REG    = 5'b10011,
		CL_DECJ_DIR    = 5'b10100,
		CL_CODE_MOVE   = 5'b10101,
		CL_XDATA_RI    = 5'b10110,
		CL_XDATA_DP    = 5'b10111,
		CL_LOAD_DP     = 5'b11000,
		CL_STACK       = 5'b11001,
		CL_NIBBLE_XCH  = 5'b11010,
		CL_CARRY_LOGIC = 5'b11011,
		CL_CARRY_ONLY  = 5'b11100,
		CL_IMM_DIRECT  = 5'b11101
	} mid_class_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} mid_state_t;

	// Next-instruction address plus a signed 8-bit offset.
	function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] rel);
		rel_target = pc + {{8{rel[7]}}, rel};
	endfunction

endpackage

// ### hdl/mid_opcode_table.sv
`timescale 1ns/1ns
`default_nettype none
module mid_opcode_table
	import mid_pkg::*;
(
	input  wire logic [7:0] opcode,
	output mid_class_t      op_class,
	output logic      [1:0] op_len,
	output logic      [2:0] base_cycles,
	output logic            is_cond
);
	always_comb begin
		op_class    = CL_OTHER;
		op_len      = 2'd1;
		base_cycles = CYC_1;
		is_cond     = 1'b0;
		casez (opcode)
			8'h00, 8'hA5: begin op_class = CL_NOP; end
			8'b???0_0001: begin op_class = CL_PAGED_JMP; op_len = 2'd2; base_cycles = CYC_3; end
			8'b???1_0001: begin op_class = CL_PAGED_CALL; op_len = 2'd2; base_cycles = CYC_3; end
			8'h02: begin op_class = CL_LONG_JMP; op_len = 2'd3; base_cycles = CYC_4; end
			8'h12: begin op_class = CL_LONG_CALL; op_len = 2'd3; base_cycles = CYC_4; end
			8'h80: begin op_class = CL_SHORT_JMP; op_len = 2'd2; base_cycles = CYC_3; end
			8'h73: begin op_class = CL_JMP_IND; base_cycles = CYC_3; end
			8'h40: begin op_class = CL_JC; op_len = 2'd2; base_cycles = CYC_2; is_cond = 1'b1; end
			8'h50: begin op_class = CL_JNC; op_len = 2'd2; base_cycles = CYC_2; is_cond = 1'b1; end
			8'h60: begin op_class = CL_JZ; op_len = 2'd2; base_cycles = CYC_2; is_cond = 1'b1; end
			8'h70: begin op_class = CL_JNZ; op_len = 2'd2; base_cycles = CYC_2; is_cond = 1'b1; end
			8'h20: begin op_class = CL_JB; op_len = 2'd3; base_cycles = CYC_3; is_cond = 1'b1; end
			8'h30: begin op_class = CL_JNB; op_len = 2'd3; base_cycles = CYC_3; is_cond = 1'b1; end
			8'h10: begin op_class = CL_JB_CLR; op_len = 2'd3; base_cycles = CYC_3; is_cond = 1'b1; end
			8'hB5: begin op_class = CL_CMPJ_DIR; op_len = 2'd3; base_cycles = CYC_3; is_cond = 1'b1; end
			8'hB4: begin op_class = CL_CMPJ_IMM; op_len = 2'd3; base_cycles = CYC_3; is_cond = 1'b1; end
			8'b1011_1???: begin op_class = CL_CMPJ_REG; op_len = 2'd3; base_cycles = CYC_3; is_cond = 1'b1; end
			8'hB6, 8'hB7: begin op_class = CL_CMPJ_IND; op_len = 2'd3; base_cycles = CYC_4; is_cond = 1'b1; end
			8'b1101_1???: begin op_class = CL_DECJ_REG; op_len = 2'd2; base_cycles = CYC_2; is_cond = 1'b1; end
			8'hD5: begin op_class = CL_DECJ_DIR; op_len = 2'd3; base_cycles = CYC_3; is_cond = 1'b1; end
			8'h93, 8'h83: begin op_class = CL_CODE_MOVE; base_cycles = CYC_3; end
			8'hE2, 8'hE3, 8'hF2, 8'hF3: begin op_class = CL_XDATA_RI; base_cycles = CYC_3; end
			8'hE0, 8'hF0: begin op_class = CL_XDATA_DP; base_cycles = CYC_3; end
			8'h90: begin op_class = CL_LOAD_DP; op_len = 2'd3; base_cycles = CYC_3; end
			8'hC0, 8'hD0: begin op_class = CL_STACK; op_len = 2'd2; base_cycles = CYC_2; end
			8'hD6, 8'hD7: begin op_class = CL_NIBBLE_XCH; base_cycles = CYC_2; end
			8'h82, 8'hB0, 8'h72, 8'hA0: begin
				op_class = CL_CARRY_LOGIC; op_len = 2'd2; base_cycles = CYC_2;
			end
			8'hC3, 8'hD3, 8'hB3: begin op_class = CL_CARRY_ONLY; end
			8'h75, 8'h53, 8'h43, 8'h63, 8'h85: begin
				op_class = CL_IMM_DIRECT; op_len = 2'd3; base_cycles = CYC_3;
			end
			default: begin op_class = CL_OTHER; end
		endcase
	end
endmodule
`default_nettype wire

// ### hdl/mid_target_calc.sv
`timescale 1ns/1ns
`default_nettype none
module mid_target_calc
	import mid_pkg::*;
(
	input  wire logic [15:0] next_pc,
	input  wire mid_class_t  op_class,
	input  wire logic [7:0]  opcode,
	input  wire logic [7:0]  operand1,
	input  wire logic [7:0]  operand2,
	input  wire logic [7:0]  acc_value,
	input  wire logic [15:0] data_pointer,
	output logic      [15:0] target
);
	always_comb begin
		unique case (op_class)
			CL_PAGED_JMP, CL_PAGED_CALL: begin
				target = {next_pc[15:11], opcode[7:5], operand1};
			end
			CL_LONG_JMP, CL_LONG_CALL: begin
				target = {operand1, operand2};
			end
			CL_JMP_IND: begin
				target = data_pointer + {8'h00, acc_value};
			end
			CL_SHORT_JMP, CL_JC, CL_JNC, CL_JZ, CL_JNZ, CL_DECJ_REG: begin
				target = rel_target(next_pc, operand1);
			end
			CL_JB, CL_JNB, CL_JB_CLR, CL_CMPJ_DIR, CL_CMPJ_IMM, CL_CMPJ_REG,
			CL_CMPJ_IND, CL_DECJ_DIR: begin
				target = rel_target(next_pc, operand2);
			end
			default: begin
				target = next_pc;
			end
		endcase
	end
endmodule
`default_nettype wire

// ### hdl/mid_core_decode.sv
// Function
// RULE1: Untaken conditional branch ends one cycle sooner.
// RULE2: Code byte moves: one byte, three cycles.
// RULE3: Six external data moves: one byte, three cycles.
// RULE4: Pointer immediate load: three bytes, three cycles.
// RULE5: Push and pop: two bytes, two cycles.
// RULE6: Nibble exchange swaps low nibbles only.
// RULE7: Carry logic two cycles; carry-only ops one.
// RULE8: Carry and zero jumps: two/three cycles.
// RULE9: Bit jumps three/four; set-and-clear clears bit.
// RULE10: Compare jumps on direct/immediate/slot: three/four.
// RULE11: Indirect compare jump takes four/five cycles.
// RULE12: Slot decrement jump two/three; direct three/four.
// RULE13: Short, paged and indirect jumps: three cycles.
// RULE14: Long call and jump: 16-bit target, four.
// RULE15: Paged target stays in next instruction's page.
// RULE16: Relative offset signed, added to next address.
// RULE17: Direct address below 0x80 is RAM.
// RULE18: Slot picks bank register; indirect uses R0/R1.
// RULE19: Undefined opcode behaves as one-cycle no-operation.
// RULE20: Pointer low byte at 0x82, resets zero.
// RULE21: Pointer high byte at 0x83, resets zero.
// RULE22: Software writes reserved bits with documented value.
// RULE23: Immediate and direct-to-direct ops: three cycles.
// RULE24: Both bytes form one shared 16-bit pointer.
`timescale 1ns/1ns
`default_nettype none
module mid_core_decode
	import mid_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        instr_start,
	input  wire logic [7:0]  opcode,
	input  wire logic [7:0]  operand1,
	input  wire logic [7:0]  operand2,
	input  wire logic [15:0] next_pc,
	input  wire logic [7:0]  acc_value,
	input  wire logic        carry_flag,
	input  wire logic        bit_value,
	input  wire logic [7:0]  operand_value,
	input  wire logic [1:0]  bank_sel,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr_en,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_rd_en,
	output logic             busy_q,
	output logic             done_q,
	output logic             covered_q,
	output logic      [1:0]  instr_len_q,
	output logic      [2:0]  instr_cycles_q,
	output logic             branch_taken_q,
	output logic      [15:0] branch_target_q,
	output logic             is_call_q,
	output logic             bit_clear_q,
	output logic      [7:0]  reg_addr_q,
	output logic      [7:0]  direct_addr_q,
	output logic             direct_is_sfr_q,
	output logic      [15:0] code_addr_q,
	output logic      [15:0] xdata_addr_q,
	output logic             xdata_wide_q,
	output logic             carry_new_q,
	output logic      [7:0]  nib_acc_q,
	output logic      [7:0]  nib_ram_q,
	output logic      [15:0] data_pointer_q,
	output logic      [7:0]  sfr_rdata_q,
	output logic             sfr_hit_q
);
	mid_class_t  op_class;
	logic [1:0]  op_len;
	logic [2:0]  base_cycles;
	logic        is_cond;
	logic [15:0] target;
	logic        cond_true;
	logic        taken;
	logic [2:0]  total_cycles;
	logic        take;
	logic [7:0]  dec_value;
	mid_state_t  state_q;
	mid_state_t  state_d;
	logic [2:0]  cnt_q;
	logic [7:0]  dp_low_q;
	logic [7:0]  dp_high_q;

	mid_opcode_table u_table (
		.opcode      (opcode),
		.op_class    (op_class),
		.op_len      (op_len),
		.base_cycles (base_cycles),
		.is_cond     (is_cond)
	);

	mid_target_calc u_target (
		.next_pc      (next_pc),
		.op_class     (op_class),
		.opcode       (opcode),
		.operand1     (operand1),
		.operand2     (operand2),
		.acc_value    (acc_value),
		.data_pointer ({dp_high_q, dp_low_q}),
		.target       (target)
	);

	assign take      = instr_start && (state_q == ST_IDLE);
	assign dec_value = operand_value - 8'h01;

	// Branch condition for each conditional class.
	always_comb begin
		unique case (op_class)
			CL_JC:       cond_true = carry_flag;                   // RULE8
			CL_JNC:      cond_true = !carry_flag;                  // RULE8
			CL_JZ:       cond_true = (acc_value == 8'h00);         // RULE8
			CL_JNZ:      cond_true = (acc_value != 8'h00);         // RULE8
			CL_JB:       cond_true = bit_value;                    // RULE9
			CL_JNB:      cond_true = !bit_value;                   // RULE9
			CL_JB_CLR:   cond_true = bit_value;                    // RULE9
			CL_CMPJ_DIR: cond_true = (acc_value != operand_value); // RULE10
			CL_CMPJ_IMM: cond_true = (acc_value != operand1);      // RULE10
			CL_CMPJ_REG: cond_true = (operand_value != operand1);  // RULE10
			CL_CMPJ_IND: cond_true = (operand_value != operand1);  // RULE11
			CL_DECJ_REG: cond_true = (dec_value != 8'h00);         // RULE12
			CL_DECJ_DIR: cond_true = (dec_value != 8'h00);         // RULE12
			default:     cond_true = 1'b0;
		endcase
	end

	// Unconditional transfers always take their target.
	always_comb begin
		unique case (op_class)
			CL_PAGED_JMP, CL_PAGED_CALL, CL_LONG_JMP, CL_LONG_CALL,
			CL_SHORT_JMP, CL_JMP_IND: taken = 1'b1; // RULE13 RULE14
			default:                  taken = is_cond && cond_true;
		endcase
	end

	// Paired figures carry the untaken count; a taken conditional branch adds one.
	assign total_cycles = base_cycles + (taken && is_cond ? CYC_TAKEN_EXTRA : 3'h0); // RULE1

	always_comb begin
		unique case (state_q)
			ST_IDLE: state_d = take ? ST_RUN : ST_IDLE;
			ST_RUN:  state_d = (cnt_q == 3'h0) ? ST_IDLE : ST_RUN;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// The counter runs the instruction for exactly its cycle figure.
	always_ff @(posedge mclk) begin
		if (srst) begin
			cnt_q  <= 3'h0;
			done_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			done_q <= (state_q == ST_RUN) && (cnt_q == 3'h0);
			busy_q <= (state_d == ST_RUN);
			if (take) begin
				cnt_q <= total_cycles - 3'h1; // RULE1 RULE2 RULE3 RULE5 RULE7 RULE19 RULE23
			end else if (state_q == ST_RUN && cnt_q != 3'h0) begin
				cnt_q <= cnt_q - 3'h1;
			end
		end
	end

	// Decode results are captured once and held until the next start.
	always_ff @(posedge mclk) begin
		if (srst) begin
			covered_q       <= 1'b0;
			instr_len_q     <= 2'd0;
			instr_cycles_q  <= 3'h0;
			branch_taken_q  <= 1'b0;
			branch_target_q <= 16'h0000;
			is_call_q       <= 1'b0;
			bit_clear_q     <= 1'b0;
		end else if (take) begin
			covered_q       <= (op_class != CL_OTHER);
			instr_len_q     <= op_len;          // RULE19
			instr_cycles_q  <= total_cycles;    // RULE11 RULE12
			branch_taken_q  <= taken;
			branch_target_q <= taken ? target : next_pc; // RULE15 RULE16
			is_call_q       <= (op_class == CL_PAGED_CALL) || (op_class == CL_LONG_CALL);
			bit_clear_q     <= (op_class == CL_JB_CLR) && cond_true; // RULE9
		end
	end

	// Operand addressing; the bank selects which eight bytes hold the slots.
	always_ff @(posedge mclk) begin
		if (srst) begin
			reg_addr_q      <= 8'h00;
			direct_addr_q   <= 8'h00;
			direct_is_sfr_q <= 1'b0;
		end else if (take) begin
			if (op_class == CL_NIBBLE_XCH || op_class == CL_XDATA_RI
					|| op_class == CL_CMPJ_IND) begin
				reg_addr_q <= {3'b000, bank_sel, 2'b00, opcode[0]}; // RULE18
			end else begin
				reg_addr_q <= {3'b000, bank_sel, opcode[SLOT_MSB:0]}; // RULE18
			end
			direct_addr_q   <= operand1;
			direct_is_sfr_q <= (operand1 >= SFR_SPACE_BASE); // RULE17
		end
	end

	// Memory addresses for code moves and external data moves.
	always_ff @(posedge mclk) begin
		if (srst) begin
			code_addr_q  <= 16'h0000;
			xdata_addr_q <= 16'h0000;
			xdata_wide_q <= 1'b0;
		end else if (take) begin
			if (opcode == OPC_CODE_MOVE_PC) begin
				code_addr_q <= next_pc + {8'h00, acc_value}; // RULE2
			end else begin
				code_addr_q <= {dp_high_q, dp_low_q} + {8'h00, acc_value}; // RULE2
			end
			xdata_wide_q <= (op_class == CL_XDATA_DP); // RULE3
			if (op_class == CL_XDATA_DP) begin
				xdata_addr_q <= {dp_high_q, dp_low_q}; // RULE3
			end else begin
				xdata_addr_q <= {8'h00, operand_value}; // RULE3
			end
		end
	end

	// Carry results and the low-nibble exchange.
	always_ff @(posedge mclk) begin
		if (srst) begin
			carry_new_q <= 1'b0;
			nib_acc_q   <= 8'h00;
			nib_ram_q   <= 8'h00;
		end else if (take) begin
			unique case (opcode)
				8'h82:   carry_new_q <= carry_flag & bit_value;  // RULE7
				8'hB0:   carry_new_q <= carry_flag & !bit_value; // RULE7
				8'h72:   carry_new_q <= carry_flag | bit_value;  // RULE7
				8'hA0:   carry_new_q <= carry_flag | !bit_value; // RULE7
				8'hC3:   carry_new_q <= 1'b0;                    // RULE7
				8'hD3:   carry_new_q <= 1'b1;                    // RULE7
				8'hB3:   carry_new_q <= !carry_flag;             // RULE7
				default: carry_new_q <= carry_flag;
			endcase
			nib_acc_q <= {acc_value[7:4], operand_value[3:0]}; // RULE6
			nib_ram_q <= {operand_value[7:4], acc_value[3:0]}; // RULE6
		end
	end

	// An instruction load wins over a register write in the same cycle,
	// because the instruction was already committed by the sequencer.
	always_ff @(posedge mclk) begin
		if (srst) begin
			dp_low_q  <= DP_BYTE_RESET; // RULE20
			dp_high_q <= DP_BYTE_RESET; // RULE21
		end else if (take && op_class == CL_LOAD_DP) begin
			dp_high_q <= operand1; // RULE4
			dp_low_q  <= operand2; // RULE4
		end else if (sfr_wr_en) begin
			if (sfr_addr == SFR_DP_LOW_ADDR) begin
				dp_low_q <= sfr_wdata; // RULE20
			end
			if (sfr_addr == SFR_DP_HIGH_ADDR) begin
				dp_high_q <= sfr_wdata; // RULE21
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			data_pointer_q <= {DP_BYTE_RESET, DP_BYTE_RESET};
		end else begin
			data_pointer_q <= {dp_high_q, dp_low_q}; // RULE24
		end
	end

	// Reads return the live byte; other addresses answer zero with no hit.
	always_ff @(posedge mclk) begin
		if (srst) begin
			sfr_rdata_q <= 8'h00;
			sfr_hit_q   <= 1'b0;
		end else if (sfr_rd_en) begin
			sfr_hit_q <= (sfr_addr == SFR_DP_LOW_ADDR) || (sfr_addr == SFR_DP_HIGH_ADDR);
			if (sfr_addr == SFR_DP_LOW_ADDR) begin
				sfr_rdata_q <= dp_low_q;  // RULE20 RULE24
			end else if (sfr_addr == SFR_DP_HIGH_ADDR) begin
				sfr_rdata_q <= dp_high_q; // RULE21 RULE24
			end else begin
				sfr_rdata_q <= 8'h00;
			end
		end else begin
			sfr_hit_q <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ### sim/mid_ram_model.sv
`timescale 1ns/1ns
`default_nettype none
// Internal data RAM behind the pointer registers. Each byte holds the inverse of
// its address, so that two neighbouring locations never read alike.
module mid_ram_model (
	input  wire logic [7:0] addr,
	output logic      [7:0] data
);
	assign data = ~addr;
endmodule
`default_nettype wire

// ### sim/mid_core_decode_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module mid_core_decode_monitor (
	input wire logic	mclk,
	input wire logic	srst,
	input wire logic	instr_start,
	input wire logic	busy_q,
	input wire logic	done_q,
	input wire logic [7:0]	opcode,
	input wire logic [7:0]	operand1,
	input wire logic [7:0]	operand2,
	input wire logic [15:0]	next_pc,
	input wire logic [7:0]	acc_value,
	input wire logic	carry_flag,
	input wire logic [7:0]	operand_value,
	input wire logic [1:0]	instr_len_q,
	input wire logic [2:0]	instr_cycles_q,
	input wire logic	branch_taken_q,
	input wire logic [15:0]	branch_target_q,
	input wire logic [7:0]	direct_addr_q,
	input wire logic	direct_is_sfr_q,
	input wire logic [7:0]	nib_acc_q,
	input wire logic [7:0]	nib_ram_q
);
	logic		take;
	logic [7:0]	op_s, o1_s, o2_s, acc_s, val_s;
	logic [15:0]	pc_s;
	logic		cy_s;
	logic [3:0]	cnt_q;
	assign take = instr_start && !busy_q;
	always_ff @(posedge mclk) begin
		if (take) begin
			op_s <= opcode;
			o1_s <= operand1;
			o2_s <= operand2;
			acc_s <= acc_value;
			val_s <= operand_value;
			pc_s <= next_pc;
			cy_s <= carry_flag;
		end
	end
	// Saturates so that a long idle spell cannot wrap into a false match.
	always_ff @(posedge mclk) begin
		if (srst || take) cnt_q <= 4'h0;
		else if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	a_done_on_count: assert property (
		done_q |-> cnt_q == {1'b0, instr_cycles_q}) else $error("done at wrong count");
	a_nop_one_cycle: assert property (
		take && (opcode == 8'h00 || opcode == 8'hA5) |=> instr_cycles_q == 3'h1
		&& instr_len_q == 2'h1 ##1 done_q) else $error("no-op timing wrong");
	a_carry_jump: assert property (
		take && opcode == 8'h40 |=> branch_taken_q == cy_s
		&& instr_cycles_q == (cy_s ? 3'h3 : 3'h2)) else $error("carry jump wrong");
	a_long_target: assert property (
		take && opcode == 8'h02 |=> branch_target_q == {o1_s, o2_s}
		&& instr_cycles_q == 3'h4) else $error("long jump wrong");
	a_paged_page: assert property (
		take && opcode[4:0] == 5'h01 |=> branch_target_q == {pc_s[15:11], op_s[7:5], o1_s})
		else $error("paged target wrong");
	a_short_rel: assert property (
		take && opcode == 8'h80 |=> branch_target_q == pc_s + {{8{o1_s[7]}}, o1_s})
		else $error("relative target wrong");
	a_direct_split: assert property (
		take |=> direct_is_sfr_q == o1_s[7] && direct_addr_q == o1_s)
		else $error("direct split wrong");
	a_nibble_swap: assert property (
		take && opcode[7:1] == 7'h6B |=> nib_acc_q == {acc_s[7:4], val_s[3:0]}
		&& nib_ram_q == {val_s[7:4], acc_s[3:0]}) else $error("nibble swap wrong");
	a_compare_jump_unequal_ind: assert property (
		take && opcode[7:1] == 7'h5B |=> instr_cycles_q == (val_s != o1_s ? 3'h5 : 3'h4))
		else $error("indirect compare timing wrong");
	c_carry_taken: cover property (take && opcode == 8'h40 && carry_flag);
	c_long_jump: cover property (take && opcode == 8'h02);
	c_nibble: cover property (take && opcode == 8'hD7);
endmodule
bind mid_core_decode mid_core_decode_monitor u_mon (.mclk(mclk), .srst(srst),
	.instr_start(instr_start), .busy_q(busy_q), .done_q(done_q), .opcode(opcode),
	.operand1(operand1), .operand2(operand2), .next_pc(next_pc), .acc_value(acc_value),
	.carry_flag(carry_flag), .operand_value(operand_value), .instr_len_q(instr_len_q),
	.instr_cycles_q(instr_cycles_q), .branch_taken_q(branch_taken_q),
	.branch_target_q(branch_target_q), .direct_addr_q(direct_addr_q),
	.direct_is_sfr_q(direct_is_sfr_q), .nib_acc_q(nib_acc_q), .nib_ram_q(nib_ram_q));
`default_nettype wire

// ### sim/mcu_core_instr_timing_decode_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mcu_core_instr_timing_decode_tb import mid_pkg::*; ;
	logic		mclk = 0, srst = 1, instr_start = 0, carry_flag = 0, bit_value = 0;
	logic		sfr_wr_en = 0, sfr_rd_en = 0;
	logic [7:0]	opcode = 0, operand1 = 0, operand2 = 0, acc_value = 0, operand_value = 0;
	logic [7:0]	sfr_addr = 0, sfr_wdata = 0, ram_addr = 0;
	logic [15:0]	next_pc = 0;
	logic [1:0]	bank_sel = 0;
	wire		busy_q, done_q, covered_q, branch_taken_q, is_call_q, bit_clear_q;
	wire		direct_is_sfr_q, xdata_wide_q, carry_new_q, sfr_hit_q;
	wire [1:0]	instr_len_q;
	wire [2:0]	instr_cycles_q;
	wire [7:0]	reg_addr_q, direct_addr_q, nib_acc_q, nib_ram_q, sfr_rdata_q, ram_data;
	wire [15:0]	branch_target_q, code_addr_q, xdata_addr_q, data_pointer_q;
	int		err_total = 0, total_checks = 0;
	logic [7:0]	mv[8] = '{8'hE2, 8'hF3, 8'hE0, 8'hF0, 8'h75, 8'h85, 8'h43, 8'h63};
	logic [7:0]	cop[5] = '{8'h82, 8'hA0, 8'hC3, 8'hD3, 8'hB3};
	logic		cfl[5] = '{1, 0, 1, 0, 1};
	logic		cres[5] = '{1, 1, 0, 1, 0};
	mid_core_decode u_dut (.mclk, .srst, .instr_start, .opcode, .operand1, .operand2,
		.next_pc, .acc_value, .carry_flag, .bit_value, .operand_value, .bank_sel,
		.sfr_addr, .sfr_wr_en, .sfr_wdata, .sfr_rd_en, .busy_q, .done_q, .covered_q,
		.instr_len_q, .instr_cycles_q, .branch_taken_q, .branch_target_q, .is_call_q,
		.bit_clear_q, .reg_addr_q, .direct_addr_q, .direct_is_sfr_q, .code_addr_q,
		.xdata_addr_q, .xdata_wide_q, .carry_new_q, .nib_acc_q, .nib_ram_q,
		.data_pointer_q, .sfr_rdata_q, .sfr_hit_q);
	mid_ram_model u_ram (.addr(ram_addr), .data(ram_data));
	always #5 mclk = ~mclk;
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (exp !== got) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Carry flag and addressed bit share one value; no scenario needs them apart.
	task automatic run(input logic [7:0] opc, o1, o2, input logic [15:0] pc,
			input logic [7:0] a, v, input logic f, input logic [1:0] ln,
			input logic [2:0] cyc, input logic [15:0] tg);
		int n;
		@(posedge mclk);
		instr_start <= 1'b1;
		opcode <= opc;
		operand1 <= o1;
		operand2 <= o2;
		next_pc <= pc;
		acc_value <= a;
		operand_value <= v;
		carry_flag <= f;
		bit_value <= f;
		@(posedge mclk);
		instr_start <= 1'b0;
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (done_q !== 1'b1 && n < 12);
		chk("length", 16'(ln), 16'(instr_len_q));
		chk("cycles", 16'(cyc), 16'(instr_cycles_q));
		chk("elapsed", 16'(cyc), 16'(n));
		chk("target", tg, branch_target_q);
	endtask
	task automatic special_function_register_space(input logic wr, input logic [7:0] ad, d, input logic hit);
		@(posedge mclk);
		sfr_wr_en <= wr;
		sfr_rd_en <= !wr;
		sfr_addr <= ad;
		sfr_wdata <= d;
		@(posedge mclk);
		sfr_wr_en <= 1'b0;
		sfr_rd_en <= 1'b0;
		#1;
		if (!wr) begin
			chk("sfr data", 16'(d), 16'(sfr_rdata_q));
			chk("sfr hit", 16'(hit), 16'(sfr_hit_q));
		end
	endtask
	task automatic t_sfr;
		special_function_register_space(1'h0, SFR_DP_LOW_ADDR, DP_BYTE_RESET, 1'h1);
		special_function_register_space(1'h0, SFR_DP_HIGH_ADDR, DP_BYTE_RESET, 1'h1);
		special_function_register_space(1'h1, SFR_DP_HIGH_ADDR, 8'h12, 1'h0);
		special_function_register_space(1'h1, SFR_DP_LOW_ADDR, 8'h34, 1'h0);
		special_function_register_space(1'h0, SFR_DP_HIGH_ADDR, 8'h12, 1'h1);
		chk("pointer", 16'h1234, data_pointer_q);
		special_function_register_space(1'h0, 8'h81, 8'h00, 1'h0);
		$display("test sfr done");
	endtask
	task automatic t_cond;
		run(8'h40, 8'h02, 8'h00, 16'h0100, 8'h00, 8'h00, 1'h1, 2'h2, 3'h3, 16'h0102);
		run(8'h40, 8'h02, 8'h00, 16'h0100, 8'h00, 8'h00, 1'h0, 2'h2, 3'h2, 16'h0100);
		run(8'h60, 8'hFE, 8'h00, 16'h0100, 8'h00, 8'h00, 1'h0, 2'h2, 3'h3, 16'h00FE);
		run(8'h70, 8'hFE, 8'h00, 16'h0100, 8'h00, 8'h00, 1'h0, 2'h2, 3'h2, 16'h0100);
		run(8'h20, 8'h20, 8'h80, 16'h0200, 8'h00, 8'h00, 1'h1, 2'h3, 3'h4, 16'h0180);
		run(8'h10, 8'h20, 8'h04, 16'h0200, 8'h00, 8'h00, 1'h1, 2'h3, 3'h4, 16'h0204);
		chk("bit clear", 16'h0001, 16'(bit_clear_q));
		run(8'hB4, 8'h05, 8'h10, 16'h0300, 8'h05, 8'h00, 1'h0, 2'h3, 3'h3, 16'h0300);
		bank_sel <= 2'h2;
		run(8'hB7, 8'h22, 8'h10, 16'h0300, 8'h00, 8'h11, 1'h0, 2'h3, 3'h5, 16'h0310);
		chk("indirect slot", 16'h0011, 16'(reg_addr_q));
		bank_sel <= 2'h3;
		run(8'hDD, 8'h05, 8'h00, 16'h0300, 8'h00, 8'h01, 1'h0, 2'h2, 3'h2, 16'h0300);
		chk("register slot", 16'h001D, 16'(reg_addr_q));
		run(8'hD5, 8'h40, 8'h04, 16'h0300, 8'h00, 8'h02, 1'h0, 2'h3, 3'h4, 16'h0304);
		$display("test conditional done");
	endtask
	task automatic t_jump;
		run(8'h80, 8'h80, 8'h00, 16'h0100, 8'h00, 8'h00, 1'h0, 2'h2, 3'h3, 16'h0080);
		run(8'h61, 8'h56, 8'h00, 16'h1234, 8'h00, 8'h00, 1'h0, 2'h2, 3'h3, 16'h1356);
		run(8'h71, 8'h56, 8'h00, 16'h1234, 8'h00, 8'h00, 1'h0, 2'h2, 3'h3, 16'h1356);
		chk("call", 16'h0001, 16'(is_call_q));
		run(8'h12, 8'h1F, 8'hAB, 16'h0100, 8'h00, 8'h00, 1'h0, 2'h3, 3'h4, 16'h1FAB);
		chk("call", 16'h0001, 16'(is_call_q));
		run(8'h02, 8'h1F, 8'hAB, 16'h0100, 8'h00, 8'h00, 1'h0, 2'h3, 3'h4, 16'h1FAB);
		run(OPC_NOP, 8'h00, 8'h00, 16'h0101, 8'h00, 8'h00, 1'h0, 2'h1, 3'h1, 16'h0101);
		run(OPC_UNDEFINED, 8'h00, 8'h00, 16'h0101, 8'h00, 8'h00, 1'h0, 2'h1, 3'h1, 16'h0101);
		chk("covered", 16'h0001, 16'(covered_q));
		run(8'h04, 8'h00, 8'h00, 16'h0101, 8'h00, 8'h00, 1'h0, 2'h1, 3'h1, 16'h0101);
		chk("covered", 16'h0000, 16'(covered_q));
		$display("test jump done");
	endtask
	task automatic t_move;
		for (int i = 0; i < 8; i++) begin
			run(mv[i], 8'h30, 8'h31, 16'h0500, 8'h00, 8'h00, 1'h0, i < 4 ? 2'h1 : 2'h3, 3'h3, 16'h0500);
		end
		run(8'hC0, 8'h7F, 8'h00, 16'h0500, 8'h00, 8'h00, 1'h0, 2'h2, 3'h2, 16'h0500);
		chk("sfr space", 16'h0000, 16'(direct_is_sfr_q));
		run(8'hD0, 8'h80, 8'h00, 16'h0500, 8'h00, 8'h00, 1'h0, 2'h2, 3'h2, 16'h0500);
		chk("sfr space", 16'h0001, 16'(direct_is_sfr_q));
		ram_addr = 8'h11;
		#1;
		run(8'hD7, 8'h00, 8'h00, 16'h0500, 8'hAB, ram_data, 1'h0, 2'h1, 3'h2, 16'h0500);
		chk("nibble acc", 16'h00AE, 16'(nib_acc_q));
		chk("nibble ram", 16'h00EB, 16'(nib_ram_q));
		for (int i = 0; i < 5; i++) begin
			run(cop[i], 8'h20, 8'h00, 16'h0500, 8'h00, 8'h00, cfl[i], i < 2 ? 2'h2 : 2'h1, i < 2 ? 3'h2 : 3'h1, 16'h0500);
			chk("carry", 16'(cres[i]), 16'(carry_new_q));
		end
		$display("test move done");
	endtask
	task automatic t_pointer;
		run(8'h90, 8'hAB, 8'hCD, 16'h0600, 8'h00, 8'h00, 1'h0, 2'h3, 3'h3, 16'h0600);
		repeat (2) @(posedge mclk);
		#1;
		chk("pointer", 16'hABCD, data_pointer_q);
		special_function_register_space(1'h0, SFR_DP_LOW_ADDR, 8'hCD, 1'h1);
		run(8'h93, 8'h00, 8'h00, 16'h0600, 8'h10, 8'h00, 1'h0, 2'h1, 3'h3, 16'h0600);
		chk("code address", 16'hABDD, code_addr_q);
		run(OPC_CODE_MOVE_PC, 8'h00, 8'h00, 16'h0400, 8'h10, 8'h00, 1'h0, 2'h1, 3'h3, 16'h0400);
		chk("code address", 16'h0410, code_addr_q);
		run(OPC_XDATA_DP_RD, 8'h00, 8'h00, 16'h0400, 8'h00, 8'h00, 1'h0, 2'h1, 3'h3, 16'h0400);
		chk("xdata address", 16'hABCD, xdata_addr_q);
		chk("xdata wide", 16'h0001, 16'(xdata_wide_q));
		$display("test pointer done");
	endtask
	initial begin
		#20000;
		err_total++;
		$display("[FAIL] watchdog expected finish seen hang");
		results;
	end
	initial begin
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		t_sfr;
		t_cond;
		t_jump;
		t_move;
		t_pointer;
		results;
	end
endmodule
`default_nettype wire
